// ### verilog/fsx_pkg.sv
package fsx_pkg;
  // frame formats
  typedef enum logic [1:0]
  {
    FSX_FRAME_NULL = 2'h0,
    FSX_FRAME_IDLE = 2'h1,
    FSX_FRAME_BUSY = 2'h3,
    FSX_FRAME_UNIMP = 2'h2
  } fsx_frame_type;
  // frame lengths in words
  localparam logic [5:0] FSX_WORDS_NULL = 6'h01;
  localparam logic [5:0] FSX_WORDS_IDLE = 6'h01;
  localparam logic [5:0] FSX_WORDS_BUSY = 6'h32;
  localparam logic [5:0] FSX_WORDS_UNIMP = 6'h16;
  // access-error frame portion read on return
  localparam logic [7:0] FSX_RET_FIRST = 8'h00;
  localparam logic [7:0] FSX_RET_LAST = 8'h0D;
  // square root command recoding
  localparam logic [6:0] FSX_SQRT_OP = 7'h04;
  localparam logic [6:0] FSX_SQRT_OP1 = 7'h05;
  localparam logic [6:0] FSX_SQRT_OP3 = 7'h21;
  // type tags
  localparam logic [2:0] FSX_TAG_NORM = 3'h0;
  localparam logic [2:0] FSX_TAG_ZERO = 3'h1;
  localparam logic [2:0] FSX_TAG_INF = 3'h2;
  localparam logic [2:0] FSX_TAG_NAN = 3'h3;
  localparam logic [2:0] FSX_TAG_XDEN = 3'h4;
  localparam logic [2:0] FSX_TAG_SDDEN = 3'h5;
  // exception bit positions, highest priority first
  localparam int FSX_EXC_UNORDERED_BRANCH_EXCEPTION = 6;
  localparam int FSX_EXC_SIGNALING_NAN_EXCEPTION = 5;
  localparam int FSX_EXC_OPERAND_ERROR_EXCEPTION = 4;
  localparam int FSX_EXC_OVERFLOW_EXCEPTION = 3;
  localparam int FSX_EXC_UNDERFLOW_EXCEPTION = 2;
  localparam int FSX_EXC_DZ = 1;
  localparam int FSX_EXC_SECOND_INEXACT_EXCEPTION = 0;
  localparam int FSX_NEXC = 7;
  // pending-at-return kinds
  localparam logic [1:0] FSX_PEND_NONE = 2'h0;
  localparam logic [1:0] FSX_PEND_TRACE = 2'h1;
  localparam logic [1:0] FSX_PEND_UNIMP = 2'h2;
  localparam logic [1:0] FSX_PEND_POST = 2'h3;
endpackage : fsx_pkg

// ### verilog/fsx_prio.sv
`timescale 1ns/100ps
module fsx_prio #(
  parameter int N = 7
) (
  input wire logic [N-1:0] i_req,
  output logic [N-1:0] o_grant,
  output logic o_any
);
  // highest index wins
  genvar g;
  generate
    for (g = 0; g < N; g++)
    begin : g_bit
      if (g == N - 1)
      begin : g_top
        assign o_grant[g] = i_req[g];
      end
      else
      begin : g_low
        assign o_grant[g] = i_req[g] & ~|i_req[N-1:g+1];
      end
    end
  endgenerate
  assign o_any = |i_req;
endmodule : fsx_prio

// ### verilog/fsx_cmd_map.sv
`timescale 1ns/100ps
module fsx_cmd_map (
  input wire logic [15:0] i_cmd,
  output logic [15:0] o_cmd1,
  output logic [15:0] o_cmd3
);
  logic [6:0] op1;
  // square root recoded in first stage
  assign op1 = (i_cmd[6:0] == fsx_pkg::FSX_SQRT_OP) ?
    fsx_pkg::FSX_SQRT_OP1 : i_cmd[6:0];
  assign o_cmd1 = {i_cmd[15:7], op1};
  // third-stage encoding from first-stage form
  assign o_cmd3 = (op1 == fsx_pkg::FSX_SQRT_OP1) ?
    {i_cmd[15:7], fsx_pkg::FSX_SQRT_OP3} :
    {i_cmd[15:7], op1[6:0]};
endmodule : fsx_cmd_map

// ### verilog/fsx_unit.sv
`timescale 1ns/100ps
module fsx_unit (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_fp_issue,
  input wire logic i_fp_unimp,
  input wire logic [15:0] i_fp_cmd,
  input wire logic i_fp_arith,
  input wire logic i_fp_packed,
  input wire logic [95:0] i_src_op,
  input wire logic [79:0] i_dst_op,
  input wire logic [2:0] i_src_tag,
  input wire logic [2:0] i_dst_tag,
  input wire logic i_pipe_busy,
  input wire logic i_pipe_blocked,
  input wire logic [6:0] i_exc_raw,
  input wire logic [6:0] i_exc_force,
  input wire logic i_exc_nu,
  input wire logic i_exc_post,
  input wire logic i_unsup_type,
  input wire logic [7:0] i_fp_control_register,
  input wire logic i_first_inexact_latch_wr,
  input wire logic i_first_inexact_latch_wdata,
  input wire logic i_fp_state_save,
  input wire logic i_fp_state_restore,
  input wire logic i_restore_null,
  input wire logic i_in_handler,
  input wire logic i_return_from_exception,
  input wire logic [1:0] i_ret_pending,
  input wire logic [7:0] i_ret_offset,
  output logic o_save_stall,
  output logic o_save_done,
  output fsx_pkg::fsx_frame_type o_frame_format,
  output logic [5:0] o_frame_words,
  output logic [15:0] o_first_stage_command_field,
  output logic [15:0] o_third_stage_command_field,
  output logic o_conversion_stage_flag,
  output logic o_normalize_stage_flag,
  output logic o_post_flag,
  output logic o_source_temp_sign,
  output logic [14:0] o_source_temp_exponent,
  output logic [63:0] o_source_temp_mantissa,
  output logic o_dest_temp_sign,
  output logic [14:0] o_dest_temp_exponent,
  output logic [63:0] o_dest_temp_mantissa,
  output logic [2:0] o_source_type_tag,
  output logic [2:0] o_destination_type_tag,
  output logic [6:0] o_exc_pending,
  output logic o_trap,
  output logic [6:0] o_trap_vector,
  output logic o_first_inexact_latch,
  output logic o_fpu_abort,
  output logic o_order_violation,
  output logic o_ret_read_en,
  output logic o_ret_start_pending,
  output logic [1:0] o_ret_kind
);
  typedef enum logic [1:0]
  {
    FSX_IDLE = 2'h0,
    FSX_WAIT = 2'h1,
    FSX_EMIT = 2'h3
  } fsx_state_type;

  typedef struct packed {
    fsx_state_type st;
    logic used;
    logic last_unimp;
    logic [6:0] exc;
    logic nu;
    logic post;
    logic cu;
    logic [15:0] cmd;
    logic packed_src;
    logic [95:0] src;
    logic [79:0] dst;
    logic [2:0] source_type_tag;
    logic [2:0] destination_type_tag;
    logic first_inexact_latch;
    logic save_done;
    fsx_pkg::fsx_frame_type fmt;
    logic [5:0] words;
    logic trap;
    logic [6:0] vec;
    logic abort;
    logic viol;
    logic saved_in_handler;
    logic ret_go;
    logic [1:0] ret_kind;
  } fsx_regs_type;

  fsx_regs_type r_q;
  fsx_regs_type r_d;
  logic [6:0] grant;
  logic any_exc;
  logic [6:0] trap_req;
  logic [15:0] cmd1;
  logic [15:0] cmd3;

  // enabled exceptions, or forced ones in bits 5 to 2, reach the trap
  assign trap_req = (i_exc_raw & i_fp_control_register[6:0]) |
    (i_exc_force & 7'h3C);

  fsx_prio #(
    .N(fsx_pkg::FSX_NEXC)
  ) u_prio (
    .i_req(trap_req),
    .o_grant(grant),
    .o_any(any_exc)
  );

  fsx_cmd_map u_map (
    .i_cmd(r_q.cmd),
    .o_cmd1(cmd1),
    .o_cmd3(cmd3)
  );

  always_comb
  begin
    r_d = r_q;
    r_d.save_done = 1'b0;
    r_d.trap = 1'b0;
    r_d.abort = 1'b0;
    r_d.viol = 1'b0;
    r_d.ret_go = 1'b0;
    // capture operands of each issued instruction
    if (i_fp_issue)
    begin
      r_d.used = 1'b1;
      r_d.last_unimp = i_fp_unimp;
      r_d.cmd = i_fp_cmd;
      r_d.packed_src = i_fp_packed;
      r_d.src = i_src_op;
      r_d.dst = i_dst_op;
      r_d.source_type_tag = i_src_tag;
      r_d.destination_type_tag = i_dst_tag;
      r_d.cu = i_unsup_type & i_fp_unimp;
      if (i_in_handler && !r_q.saved_in_handler)
      begin
        r_d.viol = 1'b1;
      end
    end
    // record raw exceptions only when a trap is requested; signal only when not saving
    if (any_exc)
    begin
      r_d.exc = r_q.exc | i_exc_raw;
      r_d.nu = i_exc_nu & i_fp_arith &
        (|(i_exc_raw & 7'h0D)) & ~(|(i_exc_raw & 7'h72));
      r_d.cu = ~r_d.nu | r_q.cu;
      r_d.post = i_exc_post;
      if (r_q.st == FSX_IDLE && !i_fp_state_save)
      begin
        r_d.trap = 1'b1;
        r_d.vec = grant;
      end
    end
    // hardware never sets the first inexact latch
    if (i_first_inexact_latch_wr)
    begin
      r_d.first_inexact_latch = i_first_inexact_latch_wdata;
    end
    if (!i_in_handler)
    begin
      r_d.saved_in_handler = 1'b0;
    end
    unique case (r_q.st)
      FSX_IDLE:
      begin
        if (i_fp_state_save)
        begin
          r_d.st = FSX_WAIT;
          if (i_in_handler)
          begin
            r_d.saved_in_handler = 1'b1;
          end
        end
      end
      FSX_WAIT:
      begin
        if (!i_pipe_busy || i_pipe_blocked)
        begin
          r_d.st = FSX_EMIT;
        end
      end
      FSX_EMIT:
      begin
        r_d.st = FSX_IDLE;
        r_d.save_done = 1'b1;
        if (!r_q.used)
        begin
          r_d.fmt = fsx_pkg::FSX_FRAME_NULL;
          r_d.words = fsx_pkg::FSX_WORDS_NULL;
        end
        else if (r_q.last_unimp)
        begin
          r_d.fmt = fsx_pkg::FSX_FRAME_UNIMP;
          r_d.words = fsx_pkg::FSX_WORDS_UNIMP;
        end
        else if (|r_q.exc)
        begin
          r_d.fmt = fsx_pkg::FSX_FRAME_BUSY;
          r_d.words = fsx_pkg::FSX_WORDS_BUSY;
        end
        else
        begin
          r_d.fmt = fsx_pkg::FSX_FRAME_IDLE;
          r_d.words = fsx_pkg::FSX_WORDS_IDLE;
        end
      end
      default:
      begin
        r_d.st = FSX_IDLE;
      end
    endcase
    // null restore returns to reset state
    if (i_fp_state_restore && i_restore_null)
    begin
      r_d = '0;
      r_d.abort = 1'b1;
    end
    // return from access error
    if (i_return_from_exception &&
      i_ret_pending != fsx_pkg::FSX_PEND_NONE)
    begin
      r_d.ret_go = 1'b1;
      r_d.ret_kind = i_ret_pending;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      r_q <= '0;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  assign o_save_stall = (r_q.st != FSX_IDLE);
  assign o_save_done = r_q.save_done;
  assign o_frame_format = r_q.fmt;
  assign o_frame_words = r_q.words;
  assign o_first_stage_command_field = cmd1;
  assign o_third_stage_command_field = cmd3;
  assign o_conversion_stage_flag = r_q.cu;
  assign o_normalize_stage_flag = r_q.nu;
  assign o_post_flag = r_q.post;
  assign o_source_temp_sign = r_q.packed_src ? 1'b0 : r_q.src[79];
  assign o_source_temp_exponent = r_q.packed_src ? 15'h0000 :
    r_q.src[78:64];
  assign o_source_temp_mantissa = r_q.src[63:0];
  assign o_dest_temp_sign = r_q.packed_src ? 1'b0 : r_q.dst[79];
  assign o_dest_temp_exponent = r_q.packed_src ? 15'h0000 :
    r_q.dst[78:64];
  assign o_dest_temp_mantissa = r_q.packed_src ?
    {32'h00000000, r_q.src[95:64]} : r_q.dst[63:0];
  assign o_source_type_tag = r_q.packed_src ? 3'h0 : r_q.source_type_tag;
  assign o_destination_type_tag = r_q.destination_type_tag;
  assign o_exc_pending = r_q.exc;
  assign o_trap = r_q.trap;
  assign o_trap_vector = r_q.vec;
  assign o_first_inexact_latch = r_q.first_inexact_latch;
  assign o_fpu_abort = r_q.abort;
  assign o_order_violation = r_q.viol;
  assign o_ret_read_en = i_return_from_exception &&
    (i_ret_offset >= fsx_pkg::FSX_RET_FIRST) &&
    (i_ret_offset <= fsx_pkg::FSX_RET_LAST);
  assign o_ret_start_pending = r_q.ret_go;
  assign o_ret_kind = r_q.ret_kind;

  property p_wait_stall;
    @(posedge i_mclk) disable iff (!i_rstn)
    (r_q.st == FSX_WAIT && i_pipe_busy && !i_pipe_blocked) |=> o_save_stall;
  endproperty
  a_wait_stall: assert property (p_wait_stall)
    else $error("save did not stall");

  property p_no_trap_saving;
    @(posedge i_mclk) disable iff (!i_rstn)
    (r_q.st == FSX_WAIT) |=> !o_trap;
  endproperty
  a_no_trap_saving: assert property (p_no_trap_saving)
    else $error("trap during save wait");

  property p_null_frame;
    @(posedge i_mclk) disable iff (!i_rstn)
    (r_q.st == FSX_EMIT && !r_q.used && !i_fp_state_restore) |=>
      (o_frame_format == fsx_pkg::FSX_FRAME_NULL);
  endproperty
  a_null_frame: assert property (p_null_frame)
    else $error("null frame expected");

  property p_busy_words;
    @(posedge i_mclk) disable iff (!i_rstn)
    (o_save_done && o_frame_format == fsx_pkg::FSX_FRAME_BUSY) |->
      (o_frame_words == 6'h32);
  endproperty
  a_busy_words: assert property (p_busy_words)
    else $error("busy frame not fifty words");

  property p_unimp_words;
    @(posedge i_mclk) disable iff (!i_rstn)
    (o_save_done && o_frame_format == fsx_pkg::FSX_FRAME_UNIMP) |->
      (o_frame_words == 6'h16);
  endproperty
  a_unimp_words: assert property (p_unimp_words)
    else $error("unimplemented frame not twenty-two words");

  property p_abort;
    @(posedge i_mclk) disable iff (!i_rstn)
    (i_fp_state_restore && i_restore_null) |=>
      (o_fpu_abort && !o_save_stall && o_exc_pending == 7'h00);
  endproperty
  a_abort: assert property (p_abort)
    else $error("null restore did not reset");

  property p_sqrt3;
    @(posedge i_mclk) disable iff (!i_rstn)
    (r_q.cmd[6:0] == 7'h04) |->
      (o_first_stage_command_field[6:0] == 7'h05 &&
       o_third_stage_command_field[6:0] == 7'h21);
  endproperty
  a_sqrt3: assert property (p_sqrt3)
    else $error("square root recoding wrong");

  property p_first_inexact_latch;
    @(posedge i_mclk) disable iff (!i_rstn)
    (!i_first_inexact_latch_wr && !(i_fp_state_restore && i_restore_null)) |=>
      $stable(o_first_inexact_latch);
  endproperty
  a_first_inexact_latch: assert property (p_first_inexact_latch)
    else $error("first inexact changed by hardware");

  property p_ret;
    @(posedge i_mclk) disable iff (!i_rstn)
    (i_return_from_exception && i_ret_pending == 2'h3) |=>
      (o_ret_start_pending && o_ret_kind == 2'h3);
  endproperty
  a_ret: assert property (p_ret)
    else $error("pending post exception not started");
endmodule : fsx_unit

// ### testbench/fsx_handler_model.sv
`timescale 1ns/100ps
module fsx_handler_model (
  input wire logic i_mclk,
  output logic o_fp_state_save,
  output logic o_pipe_busy,
  output logic o_pipe_blocked,
  output logic [6:0] o_exc_raw
);
  initial
  begin
    o_fp_state_save = 1'b0;
    o_pipe_busy = 1'b0;
    o_pipe_blocked = 1'b0;
    o_exc_raw = 7'h00;
  end
  // handler saves state before any other fp work
  task automatic run(input int n, input logic blk, input logic [6:0] exc);
    @(negedge i_mclk);
    o_fp_state_save = 1'b1;
    o_pipe_busy = (n > 0);
    o_pipe_blocked = 1'b0;
    @(negedge i_mclk);
    o_fp_state_save = 1'b0;
    o_exc_raw = exc;
    repeat (n) @(negedge i_mclk);
    o_exc_raw = 7'h00;
    o_pipe_blocked = blk;
    o_pipe_busy = blk;
  endtask : run
  task automatic raise(input logic [6:0] exc);
    @(negedge i_mclk);
    o_exc_raw = exc;
    @(negedge i_mclk);
    o_exc_raw = 7'h00;
  endtask : raise
endmodule : fsx_handler_model

// ### testbench/fsx_unit_tb.sv
`timescale 1ns/100ps
module fsx_unit_tb;
  logic i_mclk, i_rstn, i_fp_issue, i_fp_unimp, i_fp_arith, i_fp_packed;
  logic [15:0] i_fp_cmd;
  logic [95:0] i_src_op;
  logic [79:0] i_dst_op;
  logic [2:0] i_src_tag, i_dst_tag;
  logic i_pipe_busy, i_pipe_blocked, i_exc_nu, i_exc_post, i_unsup_type;
  logic [6:0] i_exc_raw, i_exc_force;
  logic [7:0] i_fp_control_register, i_ret_offset;
  logic i_first_inexact_latch_wr, i_first_inexact_latch_wdata, i_fp_state_save, i_fp_state_restore;
  logic i_restore_null, i_in_handler, i_return_from_exception;
  logic [1:0] i_ret_pending, o_ret_kind;
  logic o_save_stall, o_save_done, o_conversion_stage_flag, o_post_flag;
  fsx_pkg::fsx_frame_type o_frame_format;
  logic [5:0] o_frame_words;
  logic [15:0] o_first_stage_command_field, o_third_stage_command_field;
  logic o_normalize_stage_flag, o_source_temp_sign, o_dest_temp_sign;
  logic [14:0] o_source_temp_exponent, o_dest_temp_exponent;
  logic [63:0] o_source_temp_mantissa, o_dest_temp_mantissa;
  logic [2:0] o_source_type_tag, o_destination_type_tag;
  logic [6:0] o_exc_pending, o_trap_vector;
  logic o_trap, o_first_inexact_latch, o_fpu_abort, o_order_violation;
  logic o_ret_read_en, o_ret_start_pending;
  int fails, checked, traps, seed, m_exec, m_unimp, m_pend;
  fsx_unit fsx_unit_inst (.*);
  fsx_handler_model fsx_handler_model_inst (
    .i_mclk(i_mclk),
    .o_fp_state_save(i_fp_state_save),
    .o_pipe_busy(i_pipe_busy),
    .o_pipe_blocked(i_pipe_blocked),
    .o_exc_raw(i_exc_raw)
  );
  initial
  begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end
  always @(negedge i_mclk)
    if (o_trap === 1'b1)
      traps <= traps + 1;
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [95:0] s, e);
    checked++;
    if (s !== e)
    begin
      fails++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, e, s);
    end
  endtask : chk
  function automatic logic [1:0] exp_fmt();
    if (m_exec == 0)
      return fsx_pkg::FSX_FRAME_NULL;
    if (m_unimp != 0)
      return fsx_pkg::FSX_FRAME_UNIMP;
    if (m_pend != 0)
      return fsx_pkg::FSX_FRAME_BUSY;
    return fsx_pkg::FSX_FRAME_IDLE;
  endfunction : exp_fmt
  function automatic logic [5:0] exp_words(input logic [1:0] f);
    case (f)
      fsx_pkg::FSX_FRAME_BUSY: return fsx_pkg::FSX_WORDS_BUSY;
      fsx_pkg::FSX_FRAME_UNIMP: return fsx_pkg::FSX_WORDS_UNIMP;
      default: return fsx_pkg::FSX_WORDS_IDLE;
    endcase
  endfunction : exp_words
  task automatic save(input int n, input logic blk, input logic [6:0] exc);
    int k, t0;
    logic [1:0] f;
    m_pend = m_pend | exc;
    f = exp_fmt();
    t0 = traps;
    fsx_handler_model_inst.run(n, blk, exc);
    chk("stall", o_save_stall, 1'b1);
    k = 0;
    while (o_save_done !== 1'b1 && k < 40)
    begin
      @(posedge i_mclk);
      #1;
      k++;
    end
    chk("done", o_save_done, 1'b1);
    chk("stall_end", o_save_stall, 1'b0);
    chk("format", o_frame_format, f);
    chk("words", o_frame_words, exp_words(f));
    chk("no_trap", traps - t0, 0);
  endtask : save
  task automatic issue(input logic u, input logic pk, input logic sq);
    logic [15:0] c, e1;
    c = 16'($random(seed));
    if (sq)
      c[6:0] = fsx_pkg::FSX_SQRT_OP;
    else if (c[6:0] == fsx_pkg::FSX_SQRT_OP)
      c[0] = 1'b1;
    e1 = c;
    if (sq)
      e1[6:0] = fsx_pkg::FSX_SQRT_OP1;
    @(negedge i_mclk);
    i_fp_cmd = c;
    i_fp_unimp = u;
    i_fp_packed = pk;
    i_src_op = {$random(seed), $random(seed), $random(seed)};
    i_dst_op = 80'({$random(seed), $random(seed), $random(seed)});
    i_src_tag = 3'({$random(seed)} % 6);
    i_dst_tag = 3'({$random(seed)} % 6);
    i_fp_issue = 1'b1;
    @(negedge i_mclk);
    i_fp_issue = 1'b0;
    m_exec = 1;
    m_unimp = u;
    chk("cmd1", o_first_stage_command_field, e1);
    if (sq)
      chk("cmd3", o_third_stage_command_field[6:0], 7'h21);
    chk("src_m", o_source_temp_mantissa, i_src_op[63:0]);
    chk("destination_type_tag", o_destination_type_tag, i_dst_tag);
    if (pk)
      chk("dst_m", o_dest_temp_mantissa[31:0], i_src_op[95:64]);
    else
    begin
      chk("src_se", {o_source_temp_sign, o_source_temp_exponent},
        i_src_op[79:64]);
      chk("source_type_tag", o_source_type_tag, i_src_tag);
      chk("dst", {o_dest_temp_sign, o_dest_temp_exponent,
        o_dest_temp_mantissa}, i_dst_op);
    end
  endtask : issue
  task automatic restore_null();
    @(negedge i_mclk);
    i_fp_state_restore = 1'b1;
    i_restore_null = 1'b1;
    @(posedge i_mclk);
    #1;
    chk("abort", o_fpu_abort, 1'b1);
    @(negedge i_mclk);
    i_fp_state_restore = 1'b0;
    i_restore_null = 1'b0;
    chk("pend_clr", o_exc_pending, 7'h00);
    m_exec = 0;
    m_unimp = 0;
    m_pend = 0;
  endtask : restore_null
  task automatic trap(input logic [6:0] raw, en, frc);
    logic [6:0] eff, v;
    eff = raw & (en | (frc & 7'h3C));
    v = 7'h00;
    for (int b = 0; b < 7; b++)
      if (eff[b])
        v = 7'h01 << b;
    i_fp_control_register = {1'b0, en};
    i_exc_force = frc;
    fsx_handler_model_inst.raise(raw);
    chk("trap", o_trap, eff != 7'h00);
    if (eff != 7'h00)
      chk("vector", o_trap_vector, v);
  endtask : trap
  initial
  begin
    {i_rstn, i_fp_issue, i_fp_unimp, i_fp_arith, i_fp_packed} = 5'h00;
    {i_fp_cmd, i_src_op, i_dst_op, i_src_tag, i_dst_tag} = 'h0;
    {i_exc_force, i_exc_nu, i_exc_post, i_unsup_type} = 10'h000;
    {i_fp_control_register, i_ret_offset, i_ret_pending} = 18'h00000;
    {i_first_inexact_latch_wr, i_first_inexact_latch_wdata, i_fp_state_restore} = 3'h0;
    {i_restore_null, i_in_handler, i_return_from_exception} = 3'h0;
    {fails, checked, traps, m_exec, m_unimp, m_pend} = '0;
    seed = 58;
    repeat (3) @(negedge i_mclk);
    i_rstn = 1'b1;
    chk("rst_fmt", o_frame_format, fsx_pkg::FSX_FRAME_NULL);
    save(0, 1'b0, 7'h00);
    issue(1'b0, 1'b0, 1'b0);
    save(0, 1'b0, 7'h00);
    issue(1'b0, 1'b0, 1'b1);
    i_fp_arith = 1'b1;
    i_exc_nu = 1'b1;
    i_exc_post = 1'b1;
    i_fp_control_register = 8'h7F;
    issue(1'b0, 1'b0, 1'b1);
    save(3, 1'b1, 7'h08);
    chk("nu_flag", o_normalize_stage_flag, 1'b1);
    chk("post", o_post_flag, 1'b1);
    chk("pend", o_exc_pending, 7'h08);
    {i_fp_arith, i_exc_nu, i_exc_post} = 3'h0;
    restore_null();
    save(0, 1'b0, 7'h00);
    issue(1'b0, 1'b1, 1'b0);
    i_unsup_type = 1'b1;
    issue(1'b1, 1'b0, 1'b0);
    save(0, 1'b0, 7'h00);
    chk("cu_flag", o_conversion_stage_flag, 1'b1);
    i_unsup_type = 1'b0;
    for (int b = 0; b < 7; b++)
      trap(7'h01 << b, 7'h7F, 7'h00);
    trap(7'($random(seed)) | 7'h01, 7'h7F, 7'h00);
    trap(7'h08, 7'h00, 7'h08);
    trap(7'h02, 7'h00, 7'h02);
    trap(7'h20, 7'h00, 7'h00);
    i_in_handler = 1'b1;
    issue(1'b0, 1'b0, 1'b0);
    chk("order_bad", o_order_violation, 1'b1);
    i_in_handler = 1'b0;
    restore_null();
    i_in_handler = 1'b1;
    save(0, 1'b0, 7'h00);
    issue(1'b0, 1'b0, 1'b0);
    chk("order_ok", o_order_violation, 1'b0);
    i_in_handler = 1'b0;
    for (int k = 0; k < 4; k++)
    begin
      @(negedge i_mclk);
      i_return_from_exception = 1'b1;
      i_ret_pending = 2'(k);
      @(posedge i_mclk);
      #1;
      chk("ret_start", o_ret_start_pending, k != 0);
      if (k != 0)
        chk("ret_kind", o_ret_kind, k);
      @(negedge i_mclk);
      i_return_from_exception = 1'b0;
    end
    i_ret_pending = 2'h0;
    i_return_from_exception = 1'b1;
    for (int k = 0; k < 16; k++)
    begin
      i_ret_offset = 8'(k);
      #1;
      chk("ret_rd", o_ret_read_en, k <= 13);
    end
    i_return_from_exception = 1'b0;
    chk("first_inexact_latch_hw", o_first_inexact_latch, 1'b0);
    @(negedge i_mclk);
    {i_first_inexact_latch_wr, i_first_inexact_latch_wdata} = 2'h3;
    @(negedge i_mclk);
    {i_first_inexact_latch_wr, i_first_inexact_latch_wdata} = 2'h0;
    chk("first_inexact_latch_sw", o_first_inexact_latch, 1'b1);
    wrap_up();
  end
  initial
  begin
    #100000;
    fails++;
    wrap_up();
  end
endmodule : fsx_unit_tb
